// ### pin_partner.sv
// Far side: drives the timer input pins and counts rises of timer output 0.
// Assumes toggle requests come at least two cycles apart.
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
	input wire logic sys_clk,
	input wire logic [1:0] toggle_req,
	input wire logic [1:0] tout,
	output logic [1:0] tin_pin,
	output int rises
);
	logic last_q;
	initial begin
		tin_pin = 2'b00;
		rises = 0;
		last_q = 1'b0;
	end
	always @(posedge sys_clk) begin
		tin_pin <= tin_pin ^ toggle_req;
		last_q <= tout[0];
		if (tout[0] === 1'b1 && last_q === 1'b0) begin
			rises <= rises + 1;
		end
	end
endmodule
`default_nettype wire

// ### timer_capture_compare_ctrl.v
// Two capture/compare timers with an APB register slave and one interrupt.
// Assumes an APB master on sys_clk; timer input pins are asynchronous.
//
// Notes on behaviour
// - Interrupt raised on capture and reload events whose mask bit is set, unless the event field restricts it.
// - Elapsed time is (capture minus start) times prescale over clock rate.
// - Compare mode counts on the prescaled clock toward the 16-bit reload value.
// - On compare match raise interrupt and keep counting, no restart at one.
// - Each compare match inverts the output pin when its alternate function is on.
// - In compare mode the count wraps from all ones to zero and continues.
// - Control zero bit 7 is the top bit of the mode code.
// - Event field: 0x all events, 10 capture only, 11 reload or compare only.
// - Dead-band field delays active output edges by 0 or 2 to 128 cycles.
// - A control zero bit shows whether the last interrupt came from capture.
// - Control registers are 8-bit read/write and reset to zero.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "timer_defines.vh"

module timer_capture_compare_ctrl #(
	parameter NUM_TIMERS = 2
) (
	input wire sys_clk,
	input wire rstn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [13:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	output reg irq,
	input wire [NUM_TIMERS-1:0] tin_pin,
	input wire [NUM_TIMERS-1:0] tout_af_en,
	output wire [NUM_TIMERS-1:0] tout,
	output wire [NUM_TIMERS-1:0] tout_n
);

	reg [8*NUM_TIMERS-1:0] ctl0_q;
	reg [8*NUM_TIMERS-1:0] ctl1_q;
	reg [16*NUM_TIMERS-1:0] reload_q;
	reg [NUM_TIMERS-1:0] stat_q;
	reg [NUM_TIMERS-1:0] mask_q;

	wire [16*NUM_TIMERS-1:0] count_w;
	wire [16*NUM_TIMERS-1:0] capture_w;
	wire [NUM_TIMERS-1:0] cap_evt;
	wire [NUM_TIMERS-1:0] rel_evt;
	wire [NUM_TIMERS-1:0] cap_ok;
	wire [NUM_TIMERS-1:0] rel_ok;
	wire [NUM_TIMERS-1:0] irq_evt;
	wire [NUM_TIMERS-1:0] cnt_wr;
	wire [NUM_TIMERS-1:0] cap_wr;

	wire [`IDX_W-1:0] idx = paddr[13:2];
	wire tmr_hit = (idx[11:4] == `TMR_REGION);
	wire [2:0] ofs = idx[2:0];
	wire [2:0] tsel = {2'b00, idx[3]};
	wire xfer = psel & penable & pready;
	wire wr = xfer & pwrite;
	wire rd = xfer & ~pwrite;

	reg addr_ok;
	reg [31:0] rdata_d;

	// Address decode and read mux
	always @* begin
		addr_ok = 1'b0;
		rdata_d = 32'h0000_0000;
		if (idx == `IDX_IRQ_STAT) begin
			addr_ok = 1'b1;
			rdata_d[NUM_TIMERS-1:0] = stat_q;
		end else if (idx == `IDX_IRQ_MASK) begin
			addr_ok = 1'b1;
			rdata_d[NUM_TIMERS-1:0] = mask_q;
		end else if (tmr_hit && tsel < NUM_TIMERS) begin
			if (ofs == `IDX_COUNT) begin
				addr_ok = 1'b1;
				rdata_d[15:0] = count_w[tsel*16 +: 16];
			end else if (ofs == `IDX_RELOAD) begin
				addr_ok = 1'b1;
				rdata_d[15:0] = reload_q[tsel*16 +: 16];
			end else if (ofs == `IDX_CAPTURE) begin
				addr_ok = 1'b1;
				rdata_d[15:0] = capture_w[tsel*16 +: 16];
			end else if (ofs == `IDX_CTL0) begin
				addr_ok = 1'b1;
				rdata_d[7:0] = ctl0_q[tsel*8 +: 8];
			end else if (ofs == `IDX_CTL1) begin
				addr_ok = 1'b1;
				rdata_d[7:0] = ctl1_q[tsel*8 +: 8];
			end
		end
	end

	// APB handshake: one wait state, pready high in the second access cycle
	always @(posedge sys_clk) begin
		if (!rstn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & penable & ~pready;
			if (psel & penable & ~pready) begin
				prdata <= pwrite ? 32'h0000_0000 : rdata_d;
				pslverr <= ~addr_ok;
			end else begin
				prdata <= 32'h0000_0000;
				pslverr <= 1'b0;
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_TIMERS; g = g + 1) begin : gen_tmr
			wire [7:0] c0 = ctl0_q[g*8 +: 8];
			wire [7:0] c1 = ctl1_q[g*8 +: 8];
			wire [1:0] irq_event_select = c0[`CTL0_ISEL_HI:`CTL0_ISEL_LO];
			wire [3:0] mode_low_field = {c0[`CTL0_MODE_TOP], c1[`CTL1_MODE_HI:`CTL1_MODE_LO]};
			wire hit_me = tmr_hit & (tsel == g);

			assign cap_ok[g] = ~irq_event_select[1] | ~irq_event_select[0];
			assign rel_ok[g] = ~irq_event_select[1] | irq_event_select[0];
			assign irq_evt[g] = (cap_evt[g] & cap_ok[g]) | (rel_evt[g] & rel_ok[g]);
			assign cnt_wr[g] = wr & hit_me & (ofs == `IDX_COUNT);
			assign cap_wr[g] = wr & hit_me & (ofs == `IDX_CAPTURE);

			timer_core u_core (
				.sys_clk(sys_clk),
				.rstn(rstn),
				.enable(c1[`CTL1_EN]),
				.mode(mode_low_field),
				.prescale(c1[`CTL1_PRES_HI:`CTL1_PRES_LO]),
				.polarity(c1[`CTL1_POL]),
				.deadband_delay_sel(c0[`CTL0_DB_HI:`CTL0_DB_LO]),
				.reload(reload_q[g*16 +: 16]),
				.out_af_en(tout_af_en[g]),
				.tin_pin(tin_pin[g]),
				.cnt_wr(cnt_wr[g]),
				.cap_wr(cap_wr[g]),
				.wdata(pwdata[15:0]),
				.count_q(count_w[g*16 +: 16]),
				.capture_q(capture_w[g*16 +: 16]),
				.cap_evt_q(cap_evt[g]),
				.rel_evt_q(rel_evt[g]),
				.tout_q(tout[g]),
				.tout_n_q(tout_n[g])
			);
		end
	endgenerate

	integer t;

	// Control, reload and interrupt registers
	always @(posedge sys_clk) begin
		if (!rstn) begin
			ctl0_q <= {NUM_TIMERS{`CTL_RST}};
			ctl1_q <= {NUM_TIMERS{`CTL_RST}};
			reload_q <= {NUM_TIMERS{`WORD_RST}};
			stat_q <= {NUM_TIMERS{1'b0}};
			mask_q <= {NUM_TIMERS{1'b0}};
			irq <= 1'b0;
		end else begin
			for (t = 0; t < NUM_TIMERS; t = t + 1) begin
				if (wr && tmr_hit && tsel == t) begin
					if (ofs == `IDX_CTL0)
						ctl0_q[t*8 +: 8] <= pwdata[7:0];
					else if (ofs == `IDX_CTL1)
						ctl1_q[t*8 +: 8] <= pwdata[7:0];
					else if (ofs == `IDX_RELOAD)
						reload_q[t*16 +: 16] <= pwdata[15:0];
				end
				// Hardware update of the cause flag wins over a software write
				if (cap_evt[t] && cap_ok[t])
					ctl0_q[t*8 + `CTL0_CAPFLAG] <= 1'b1;
				else if (rel_evt[t] && rel_ok[t])
					ctl0_q[t*8 + `CTL0_CAPFLAG] <= 1'b0;
			end
			// Status clears on read; a new event in the same cycle survives
			if (rd && idx == `IDX_IRQ_STAT)
				stat_q <= irq_evt;
			else
				stat_q <= stat_q | irq_evt;
			if (wr && idx == `IDX_IRQ_MASK)
				mask_q <= pwdata[NUM_TIMERS-1:0];
			if (rd && idx == `IDX_IRQ_STAT)
				irq <= |(irq_evt & mask_q);
			else
				irq <= |((stat_q | irq_evt) & mask_q);
		end
	end

endmodule
`default_nettype wire

// ### timer_capture_compare_ctrl_props.sv
// Assertions on the APB answer, interrupt and timer outputs.
// Bound into timer_capture_compare_ctrl; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module tcc_props #(
	parameter NUM_TIMERS = 2
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic irq,
	input wire logic [NUM_TIMERS-1:0] tout,
	input wire logic [NUM_TIMERS-1:0] tout_n
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	a_ready_single: assert property (pready |=> !pready)
		else $error("pready held too long");
	a_ready_access: assert property (pready |-> psel && penable)
		else $error("pready outside access");
	a_one_wait: assert property (psel && $rose(penable) |=> pready)
		else $error("no answer after one wait");
	a_err_qual: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("bad error response");
	a_data_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	a_reset_quiet: assert property (!$past(rstn) |-> !irq && !pready && tout == '0 && tout_n == '0)
		else $error("outputs not cleared by reset");
	a_outs_apart: assert property ((tout & tout_n) == '0)
		else $error("output and complement both active");
	a_irq_fall: assert property ($fell(irq) |-> $past(pready) || $past(pready, 2) || $past(pready, 3))
		else $error("interrupt dropped without access");
endmodule
bind timer_capture_compare_ctrl tcc_props #(.NUM_TIMERS(NUM_TIMERS)) u_props (.sys_clk(sys_clk), .rstn(rstn),
	.psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
	.tout(tout), .tout_n(tout_n));
`default_nettype wire

// ### timer_capture_compare_ctrl_tb.sv
// Self-checking bench for timer_capture_compare_ctrl.
// Drives APB; pin_partner stands on the timer pins.
`timescale 1ns/1ps
`default_nettype none
module timer_capture_compare_ctrl_tb;
	typedef struct {logic [13:0] a; logic [31:0] d; logic [31:0] x; logic e;} row_t;
	logic sys_clk, rstn, psel, penable, pwrite, pready, pslverr, irq, er;
	logic [13:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] tin_pin, tout_af_en, tout, tout_n, tog;
	int rises, err_count, n_tests;
	row_t rows[5] = '{'{14'h3c18, 32'hae, 32'hae, 1'b0}, '{14'h3c38, 32'h6c, 32'h6c, 1'b0},
		'{14'h3c08, 32'h1234, 32'h1234, 1'b0}, '{14'h3c20, 32'hbeef, 32'hbeef, 1'b0},
		'{14'h3ffc, 32'h55, 32'h0, 1'b1}};
	timer_capture_compare_ctrl u_dut (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irq(irq), .tin_pin(tin_pin), .tout_af_en(tout_af_en), .tout(tout), .tout_n(tout_n));
	pin_partner u_pins (.sys_clk(sys_clk), .toggle_req(tog), .tout(tout), .tin_pin(tin_pin), .rises(rises));
	task automatic final_report;
		$display("tests %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic stop_run;
		err_count++;
		final_report();
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
		int i;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge sys_clk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i >= 20) stop_run();
	endtask
	task automatic wr(input logic [13:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input logic [13:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(rd, x);
	endtask
	task automatic do_reset;
		@(posedge sys_clk);
		rstn <= 1'b0;
		repeat (5) @(posedge sys_clk);
		rstn <= 1'b1;
	endtask
	task automatic wait_irq;
		int i;
		for (i = 0; irq !== 1'b1; i++) begin
			if (i >= 300) stop_run();
			@(posedge sys_clk);
		end
	endtask
	task automatic pulse;
		@(posedge sys_clk);
		tog <= 2'b10;
		@(posedge sys_clk);
		tog <= 2'b00;
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	initial begin
		{rstn, psel, penable, pwrite, paddr, pwdata, tog, err_count, n_tests} = '0;
		tout_af_en = 2'b11;
		do_reset();
		rdc(14'h3c18, 32'h0);
		rdc(14'h3c38, 32'h0);
		foreach (rows[k]) begin
			wr(rows[k].a, rows[k].d);
			apb(1'b0, rows[k].a, 32'h0);
			chk(rd, rows[k].x);
			chk(er, rows[k].e);
		end
		do_reset();
		rdc(14'h3c18, 32'h0);
		// Compare from fffd to 0002 crosses the wrap
		wr(14'h3c1c, 32'h03);
		wr(14'h3c00, 32'hfffd);
		wr(14'h3c08, 32'h2);
		wr(14'h3c44, 32'h1);
		wr(14'h3c1c, 32'h83);
		wait_irq();
		apb(1'b0, 14'h3c00, 32'h0);
		chk(rd > 2 && rd < 32'h40, 1);
		rdc(14'h3c40, 32'h1);
		rdc(14'h3c40, 32'h0);
		rdc(14'h3c18, 32'h0);
		chk(rises, 1);
		chk({tout_n, tout}, 32'h9);
		// Capture-only filter hides a compare match
		wr(14'h3c1c, 32'h03);
		wr(14'h3c18, 32'h40);
		wr(14'h3c00, 32'h0);
		wr(14'h3c08, 32'h10);
		wr(14'h3c1c, 32'h83);
		repeat (40) @(posedge sys_clk);
		rdc(14'h3c40, 32'h0);
		chk(rises, 2);
		wr(14'h3c1c, 32'h03);
		// Top mode bit set: capture must not happen
		wr(14'h3c3c, 32'h04);
		wr(14'h3c30, 32'h0);
		wr(14'h3c28, 32'hffff);
		wr(14'h3c38, 32'h80);
		wr(14'h3c3c, 32'h84);
		pulse();
		pulse();
		repeat (5) @(posedge sys_clk);
		rdc(14'h3c30, 32'h0);
		wr(14'h3c38, 32'h0);
		wr(14'h3c20, 32'h100);
		pulse();
		repeat (4) @(posedge sys_clk);
		chk(irq, 0);
		apb(1'b0, 14'h3c30, 32'h0);
		chk(rd >= 32'h102 && rd <= 32'h108, 1);
		wr(14'h3c44, 32'h3);
		wait_irq();
		rdc(14'h3c40, 32'h2);
		rdc(14'h3c38, 32'h1);
		repeat (3) @(posedge sys_clk);
		chk(irq, 0);
		final_report();
	end
endmodule
`default_nettype wire

// ### timer_core.v
// One 16-bit counter/timer: prescaler, reload/compare, capture, output
// toggling and dead-band. Register storage for control lives in the parent.
// Assumes tin_pin is asynchronous and all other inputs are on sys_clk.
`timescale 1ns/1ps
`default_nettype none
`include "timer_defines.vh"

module timer_core (
	input wire sys_clk,
	input wire rstn,
	input wire enable,
	input wire [3:0] mode,
	input wire [2:0] prescale,
	input wire polarity,
	input wire [2:0] deadband_delay_sel,
	input wire [15:0] reload,
	input wire out_af_en,
	input wire tin_pin,
	input wire cnt_wr,
	input wire cap_wr,
	input wire [15:0] wdata,
	output reg [15:0] count_q,
	output reg [15:0] capture_q,
	output reg cap_evt_q,
	output reg rel_evt_q,
	output reg tout_q,
	output reg tout_n_q
);

	reg [6:0] pre_q;
	reg tin_s1_q, tin_s2_q, tin_s3_q;
	reg level_q, level_d_q;
	reg [7:0] db_cnt_q;
	wire [6:0] pre_mask = (7'h01 << prescale) - 7'h01;
	wire tick = enable & ((pre_q & pre_mask) == pre_mask);
	wire is_cmp = (mode == `MODE_COMPARE);
	wire is_cap = (mode == `MODE_CAPTURE);
	wire match = (count_q == reload);
	wire cap_edge = (tin_s2_q != tin_s3_q) & (tin_s2_q == ~polarity);
	wire [7:0] db_need = (deadband_delay_sel == 3'h0) ? 8'h00 : (8'h01 << deadband_delay_sel);
	wire db_done = (db_cnt_q >= db_need);
	wire level_chg = (level_q != level_d_q);

	always @(posedge sys_clk) begin
		if (!rstn) begin
			pre_q <= 7'h00;
			tin_s1_q <= 1'b0;
			tin_s2_q <= 1'b0;
			tin_s3_q <= 1'b0;
			count_q <= `WORD_RST;
			capture_q <= `WORD_RST;
			cap_evt_q <= 1'b0;
			rel_evt_q <= 1'b0;
			level_q <= 1'b0;
			level_d_q <= 1'b0;
			db_cnt_q <= 8'h00;
			tout_q <= 1'b0;
			tout_n_q <= 1'b0;
		end else begin
			tin_s1_q <= tin_pin;
			tin_s2_q <= tin_s1_q;
			tin_s3_q <= tin_s2_q;
			cap_evt_q <= 1'b0;
			rel_evt_q <= 1'b0;
			if (enable)
				pre_q <= pre_q + 7'h01;
			else
				pre_q <= 7'h00;
			if (cnt_wr) begin
				count_q <= wdata;
			end else if (tick) begin
				if (match) begin
					rel_evt_q <= 1'b1;
					if (is_cmp)
						count_q <= count_q + 16'h0001;
					else
						count_q <= `COUNT_RESTART;
				end else begin
					count_q <= count_q + 16'h0001;
				end
			end
			// Capture edge wins over a simultaneous software preset
			if (enable && is_cap && cap_edge) begin
				capture_q <= count_q;
				cap_evt_q <= 1'b1;
			end else if (cap_wr) begin
				capture_q <= wdata;
			end
			if (!enable)
				level_q <= polarity;
			else if (tick && match && is_cmp && out_af_en)
				level_q <= ~level_q;
			level_d_q <= level_q;
			// Active-going edges of both outputs wait for the dead-band
			if (level_chg)
				db_cnt_q <= 8'h00;
			else if (!db_done)
				db_cnt_q <= db_cnt_q + 8'h01;
			tout_q <= level_q & db_done & (~level_chg | (db_need == 8'h00));
			tout_n_q <= ~level_q & db_done & (~level_chg | (db_need == 8'h00));
		end
	end

endmodule
`default_nettype wire

// ### timer_defines.vh
// Register indices, field positions, reset values and mode codes of the
// dual capture/compare timer; included by both design files.
`ifndef TIMER_DEFINES_VH
`define TIMER_DEFINES_VH

// Word index of a register; byte address on APB is four times the index
`define IDX_W 12
`define TMR_REGION 8'hf0
`define IDX_COUNT 3'h0
`define IDX_RELOAD 3'h2
`define IDX_CAPTURE 3'h4
`define IDX_CTL0 3'h6
`define IDX_CTL1 3'h7
`define IDX_T0_CTL0 12'hf06
`define IDX_T1_CTL0 12'hf0e
`define IDX_IRQ_STAT 12'hf10
`define IDX_IRQ_MASK 12'hf11

// timer_control_zero fields
`define CTL0_MODE_TOP 7
`define CTL0_ISEL_HI 6
`define CTL0_ISEL_LO 5
`define CTL0_RSVD 4
`define CTL0_DB_HI 3
`define CTL0_DB_LO 1
`define CTL0_CAPFLAG 0

// timer_control_one fields
`define CTL1_EN 7
`define CTL1_POL 6
`define CTL1_PRES_HI 5
`define CTL1_PRES_LO 3
`define CTL1_MODE_HI 2
`define CTL1_MODE_LO 0

`define CTL_RST 8'h00
`define WORD_RST 16'h0000
`define COUNT_RESTART 16'h0001

// Four-bit mode codes {mode_top_bit, mode_low_field}
`define MODE_COMPARE 4'h3
`define MODE_CAPTURE 4'h4

`define SYS_CLK_HZ 10000000

`endif
